/* File: logic/roma_pkg.sv */
package roma_pkg;
  // array geometry
  localparam int CELLS = 10;
  localparam int DED_INPUTS = 10;
  localparam int DATA_TERMS = 4;
  localparam int TERMS_PER_CELL = 8;
  localparam int ROWS = CELLS * TERMS_PER_CELL;
  localparam int COLS = 3 * CELLS;
  localparam int FUSE_W = 2 * COLS;

  // term slots inside one cell's group of rows
  localparam int T_CLK = 4;
  localparam int T_RST = 5;
  localparam int T_PRE = 6;
  localparam int T_OE = 7;

  // register byte addresses
  localparam logic [11:0] ADR_CTRL = 12'h000;
  localparam logic [11:0] ADR_STATE = 12'h004;
  localparam logic [11:0] ADR_PINS = 12'h008;
  localparam logic [11:0] ADR_TERMS0 = 12'h00c;
  localparam logic [11:0] ADR_TERMS1 = 12'h010;
  localparam logic [11:0] ADR_TERMS2 = 12'h014;
  localparam logic [1:0] FUSE_REGION = 2'h1;

  // field positions
  localparam int STATE_DRIVE_LSB = 10;
  localparam int STATE_NODE_LSB = 20;
  localparam int PINS_IO_LSB = 10;
  localparam int PINS_PRELOAD_BIT = 20;
  localparam int PINS_OEN_BIT = 21;

  // values after reset, fuse write mask and unmapped read value
  localparam logic [9:0] POLARITY_RST = 10'h3ff;
  localparam logic [63:0] FUSE_RST = 64'h0;
  localparam logic [63:0] FUSE_MASK = 64'h0fff_ffff_ffff_ffff;
  localparam logic [31:0] UNMAPPED_RD = 32'h0;
endpackage

/* File: logic/roma_output_logic_cell.sv */
`timescale 1ns/10ps
// one output logic cell: data sum, polarity xor, term-clocked flip-flop,
// level reset and preset, register bypass, preload and inverting tri-state drive
module roma_output_logic_cell
  import roma_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [DATA_TERMS-1:0] data_term,
  input wire logic clk_term,
  input wire logic rst_term,
  input wire logic pre_term,
  input wire logic oe_term,
  input wire logic polarity,
  input wire logic oe_common_n,
  input wire logic preload_n,
  input wire logic pin_level,
  output logic ff_q,
  output logic node,
  output logic pin_o,
  output logic pin_oe_n
);
  logic clk_term_q;
  logic d;
  logic clk_edge;
  logic bypass;
  logic next_q;
  logic next_node;
  logic next_drive;

  assign d = (|data_term) ^ polarity;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      clk_term_q <= 1'b0;
    else
      clk_term_q <= clk_term;
  end
  assign clk_edge = clk_term & ~clk_term_q;

  assign bypass = rst_term & pre_term;

  // flip-flop next state; preload outranks every term
  always_comb
  begin
    next_q = ff_q;
    if (!preload_n)
    begin
      if (pin_oe_n)
        next_q = ~pin_level;
    end
    else if (bypass)
      next_q = ff_q;
    else if (rst_term)
      next_q = 1'b0;
    else if (pre_term)
      next_q = 1'b1;
    else if (clk_edge)
      next_q = d; // polarity here and on the bypass node
  end

  assign next_node = (bypass && preload_n) ? d : next_q;
  assign next_drive = oe_term & ~oe_common_n;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ff_q <= 1'b0;
      node <= 1'b0;
      pin_o <= 1'b1;
      pin_oe_n <= 1'b1;
    end
    else
    begin
      ff_q <= next_q;
      node <= next_node;
      pin_o <= ~next_node;
      pin_oe_n <= ~next_drive;
    end
  end
endmodule

/* File: logic/roma_macrocell_array.sv */
`timescale 1ns/10ps
// What this block does
// - ten flip-flops, each with own reset, preset, clock terms
// - data input is OR of four terms through polarity xor
// - ten dedicated inputs, ten two-way pins, each into the array
// - flip-flop captures only on its own clock term edge
// - clock terms use any pins or feedback; ten clocks possible
// - polarity zero gives active-low pin, one active-high
// - output buffer inverts the node level
// - polarity affects clocked and bypassed data only, not reset, preset, preload
// - pin driven only with enable term on and common enable low
// - reset and preset are levels holding the flip-flop
// - reset gives zero (pin high), preset gives one (pin low)
// - neither term active: normal clocked register
// - both active: register bypassed, output combinatorial
// - bypass follows live terms, switchable at run time
// - all ten cells have identical term resources
// - reset clears every flip-flop before use
// - preload low loads flip-flops from disabled pins, inverted
module roma_macrocell_array
  import roma_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [DED_INPUTS-1:0] ded_in,
  input wire logic preload_n,
  input wire logic oe_common_n,
  input wire logic [CELLS-1:0] io_in,
  output logic [CELLS-1:0] io_out,
  output logic [CELLS-1:0] io_oe_n
);
  // fuse rows: bit c connects literal c; low half true, high half complement
  logic [63:0] fuse_mem [0:ROWS-1];
  logic [CELLS-1:0] polarity;
  logic [CELLS-1:0] ff_q;
  logic [CELLS-1:0] node;
  logic [CELLS-1:0] pin_col;
  logic [COLS-1:0] col;
  logic [FUSE_W-1:0] lit;
  logic [ROWS-1:0] term;
  logic req;
  logic wr_en;
  logic fuse_hit;
  logic [6:0] fuse_row;
  logic fuse_half;
  logic [31:0] next_rd;

  // disabled pin reads outside
  // an enabled pin feeds back its own registered drive, which keeps the
  // array free of loops through the board at the cost of one cycle
  assign pin_col = (io_oe_n & io_in) | (~io_oe_n & io_out);

  assign col = {node, pin_col, ded_in};
  assign lit = {~col, col};

  // product terms; a row with no fuse is inactive so a blank part is quiet
  genvar r;
  generate
    for (r = 0; r < ROWS; r++)
    begin : g_term
      assign term[r] = (|fuse_mem[r][FUSE_W-1:0]) &
                       (&(~fuse_mem[r][FUSE_W-1:0] | lit));
    end
  endgenerate

  genvar c;
  generate
    for (c = 0; c < CELLS; c++)
    begin : g_cell
      roma_output_logic_cell roma_output_logic_cell_i (
        .sys_clk(sys_clk),
        .rst(rst),
        .data_term(term[c*TERMS_PER_CELL +: DATA_TERMS]),
        .clk_term(term[c*TERMS_PER_CELL + T_CLK]),
        .rst_term(term[c*TERMS_PER_CELL + T_RST]),
        .pre_term(term[c*TERMS_PER_CELL + T_PRE]),
        .oe_term(term[c*TERMS_PER_CELL + T_OE]),
        .polarity(polarity[c]),
        .oe_common_n(oe_common_n),
        .preload_n(preload_n),
        .pin_level(pin_col[c]),
        .ff_q(ff_q[c]),
        .node(node[c]),
        .pin_o(io_out[c]),
        .pin_oe_n(io_oe_n[c])
      );
    end
  endgenerate

  // bus decode; one wait state, ack answers any address
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = req & wb_we_i;
  assign fuse_hit = (wb_adr_i[11:10] == FUSE_REGION) && (wb_adr_i[9:3] < 7'(ROWS));
  assign fuse_row = wb_adr_i[9:3];
  assign fuse_half = wb_adr_i[2];

  // ack rises one cycle after the request and drops the next
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req;
  end

  // polarity bits; software steers the xor of every cell
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      polarity <= POLARITY_RST;
    else if (wr_en && wb_adr_i == ADR_CTRL)
    begin
      if (wb_sel_i[0])
        polarity[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1])
        polarity[9:8] <= wb_dat_i[9:8];
    end
  end

  // fuse rows, byte-lane writes; bits above the row width stay zero
  generate
    for (r = 0; r < ROWS; r++)
    begin : g_fuse
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
          fuse_mem[r] <= FUSE_RST;
        else if (wr_en && fuse_hit && fuse_row == 7'(r))
        begin
          for (int b = 0; b < 4; b++)
          begin
            if (wb_sel_i[b])
              fuse_mem[r][32*fuse_half + 8*b +: 8] <= wb_dat_i[8*b +: 8] &
                FUSE_MASK[32*fuse_half + 8*b +: 8];
          end
        end
      end
    end
  endgenerate

  // read mux; unmapped addresses read zero
  always_comb
  begin
    next_rd = UNMAPPED_RD;
    if (fuse_hit)
      next_rd = fuse_half ? fuse_mem[fuse_row][63:32] : fuse_mem[fuse_row][31:0];
    else
    begin
      case (wb_adr_i)
        ADR_CTRL: next_rd[CELLS-1:0] = polarity;
        ADR_STATE:
        begin
          next_rd[CELLS-1:0] = ff_q;
          next_rd[STATE_DRIVE_LSB +: CELLS] = ~io_oe_n;
          next_rd[STATE_NODE_LSB +: CELLS] = node;
        end
        ADR_PINS:
        begin
          next_rd[DED_INPUTS-1:0] = ded_in;
          next_rd[PINS_IO_LSB +: CELLS] = io_in;
          next_rd[PINS_PRELOAD_BIT] = preload_n;
          next_rd[PINS_OEN_BIT] = oe_common_n;
        end
        ADR_TERMS0: next_rd = term[31:0];
        ADR_TERMS1: next_rd = term[63:32];
        ADR_TERMS2: next_rd[ROWS-65:0] = term[ROWS-1:64];
        default: next_rd = UNMAPPED_RD;
      endcase
    end
  end

  // read data held from the ack edge
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      wb_dat_o <= UNMAPPED_RD;
    else if (req)
      wb_dat_o <= next_rd;
  end
endmodule

/* File: tb/roma_macrocell_array_assertions.sv */
`timescale 1ns/10ps
// watches the bus handshake and the pin drivers from the top ports only
module roma_chk
  import roma_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [11:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic preload_n,
  input wire logic oe_common_n,
  input wire logic [CELLS-1:0] io_in,
  input wire logic [CELLS-1:0] io_out,
  input wire logic [CELLS-1:0] io_oe_n
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  hole_read_a: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 12'h020
    |-> wb_dat_o == UNMAPPED_RD)
    else $error("unmapped read not zero");
  reset_idle_a: assert property ($fell(rst) |-> &io_oe_n && &io_out)
    else $error("pins not idle after reset");
  common_off_a: assert property (oe_common_n |=> &io_oe_n)
    else $error("pin driven with common enable high");
  drive_cause_a: assert property (!(&io_oe_n) |-> !$past(oe_common_n))
    else $error("drive without common enable");
  preload_load_a: assert property (
    (!preload_n && oe_common_n && $stable(io_in)) [*3] |-> io_out == io_in)
    else $error("preload not taken from pins");
  // a cell driving its pin through two preload cycles must not move its pin
  preload_keep_a: assert property (!preload_n && $past(!preload_n) |=>
    (($past(io_out) ^ io_out) & ~$past(io_oe_n) & ~$past(io_oe_n, 2)) == 10'h000)
    else $error("driving cell changed during preload");
endmodule
bind roma_macrocell_array roma_chk roma_chk_i (.sys_clk, .rst, .wb_adr_i, .wb_we_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .wb_dat_o, .preload_n, .oe_common_n, .io_in, .io_out, .io_oe_n);

/* File: tb/roma_board.sv */
`timescale 1ns/10ps
// board around the two-way pins; pull-ups hold released pins high
module roma_board
  import roma_pkg::*;
(
  input wire logic [CELLS-1:0] io_out,
  input wire logic [CELLS-1:0] io_oe_n,
  input wire logic [CELLS-1:0] drv_en,
  input wire logic [CELLS-1:0] drv_val,
  output logic [CELLS-1:0] io_in
);
  assign io_in = (~io_oe_n & io_out) | (io_oe_n & drv_en & drv_val) | (io_oe_n & ~drv_en);
endmodule

/* File: tb/roma_macrocell_array_test.sv */
`timescale 1ns/10ps
module roma_macrocell_array_test import roma_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] wb_adr_i = 12'h000;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'hf;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_ack_o;
  logic [9:0] ded_in = 10'h000;
  logic preload_n = 1'b1;
  logic oe_common_n = 1'b0;
  logic [9:0] io_in;
  logic [9:0] io_out;
  logic [9:0] io_oe_n;
  logic [9:0] drv_en = 10'h000;
  logic [9:0] drv_val = 10'h000;
  int errors = 0;
  int total_checks = 0;
  int rw[5] = '{0, 4, 5, 6, 7};
  int cl[5] = '{1, 2, 3, 4, 0};
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  roma_macrocell_array roma_macrocell_array_i (.sys_clk, .rst, .wb_adr_i, .wb_dat_i, .wb_dat_o,
    .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ded_in, .preload_n, .oe_common_n,
    .io_in, .io_out, .io_oe_n);
  roma_board roma_board_i (.io_out, .io_oe_n, .drv_en, .drv_val, .io_in);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one classic cycle; read data is taken at the edge that sees ack
  task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] q);
    @(posedge sys_clk);
    wb_we_i <= we;
    wb_sel_i <= s;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do
      @(posedge sys_clk);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, 4'hf, q);
  endtask
  // write through the chosen byte lanes only
  task automatic wrs(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    acc(1'b1, a, d, s, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, 4'hf, q);
    chk(q, e);
  endtask
  // cells 0 and 5 carry the pattern, the other eight stay idle and high
  task automatic step(input logic [9:0] d, input logic pin, input logic drv);
    @(posedge sys_clk);
    ded_in <= d;
    repeat (3) @(posedge sys_clk);
    chk(32'({io_oe_n, io_out}), 32'({drv ? 10'h3de : 10'h3ff, pin ? 10'h3ff : 10'h3de}));
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ded_in bits: 0 enable, 1 data, 2 clock, 3 reset, 4 preset
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(ADR_CTRL, 32'(POLARITY_RST));
    rd(ADR_STATE, 32'h0);
    rd(12'h020, UNMAPPED_RD);
    wr(12'h40c, 32'hffff_ffff);
    rd(12'h40c, 32'h0fff_ffff);
    for (int c = 0; c < 10; c += 5)
      for (int i = 0; i < 5; i++)
        wr(12'h400 + 12'(8 * (c * 8 + rw[i])), 32'h1 << cl[i]);
    $display("registers done");
    step(10'h001, 1'b1, 1'b1);
    step(10'h005, 1'b0, 1'b1);
    rd(ADR_STATE, 32'h0210_8421);
    rd(ADR_PINS, 32'h001f_7805);
    rd(ADR_TERMS0, 32'h0000_0090);
    rd(ADR_TERMS1, 32'h0000_9000);
    rd(ADR_TERMS2, 32'h0);
    step(10'h007, 1'b0, 1'b1);
    step(10'h003, 1'b0, 1'b1);
    // low lane only: the two upper polarity bits must stay set
    wrs(ADR_CTRL, 32'h0000_00de, 4'h1);
    rd(ADR_CTRL, 32'h0000_03de);
    step(10'h005, 1'b1, 1'b1);
    step(10'h015, 1'b0, 1'b1);
    step(10'h009, 1'b1, 1'b1);
    step(10'h00f, 1'b1, 1'b1);
    step(10'h01b, 1'b0, 1'b1);
    step(10'h019, 1'b1, 1'b1);
    step(10'h007, 1'b0, 1'b1);
    // cell 2: data from the released pin 3, clock from cell 0's flip-flop
    drv_en <= 10'h008;
    wr(12'h480, 32'h0000_2000);
    wr(12'h4a0, 32'h0010_0000);
    rd(ADR_STATE, 32'h0250_8425);
    // preload while cells 0 and 5 still drive: those two keep their state
    preload_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(ADR_STATE, 32'h0290_8429);
    $display("cells done");
    oe_common_n <= 1'b1;
    drv_en <= 10'h3ff;
    drv_val <= 10'h3ff;
    preload_n <= 1'b0;
    step(10'h007, 1'b1, 1'b0);
    drv_val <= 10'h3de;
    step(10'h007, 1'b0, 1'b0);
    // idle cycles so the pin-level preload check gets to complete
    repeat (3) @(posedge sys_clk);
    $display("preload done");
    // second reset in mid-run, with the preload pin still low
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    preload_n <= 1'b1;
    rd(ADR_STATE, 32'h0);
    rd(ADR_CTRL, 32'(POLARITY_RST));
    $display("reset done");
    results();
  end
  // whole run is under two hundred cycles; this only cuts a hang short
  initial
  begin
    #50us;
    errors++;
    results();
  end
endmodule
